// [core/wscp_defs.vh]
`ifndef WSCP_DEFS_VH
`define WSCP_DEFS_VH

// ****************************************
// Command bus
// ****************************************
`define WSCP_KEY_W 68
`define WSCP_OP_SEARCH 2'h2
`define WSCP_CMD_OP 1:0
`define WSCP_CMD_ZERO 2
`define WSCP_CMD_GMR 5:3
`define WSCP_CMD_HI 8:6
`define WSCP_CMD_CMP 5:2
`define WSCP_CMD_SSR 8:6

// ****************************************
// Table size codes and latencies
// ****************************************
`define WSCP_TABLE_SIZE_FIELD_ONE 2'h0
`define WSCP_TABLE_SIZE_FIELD_EIGHT 2'h1
`define WSCP_TABLE_SIZE_FIELD_FULL 2'h2
`define WSCP_LAT_ONE 4
`define WSCP_LAT_EIGHT 5
`define WSCP_LAT_FULL 6

// ****************************************
// Register map (word index)
// ****************************************
`define WSCP_REG_CONFIG 6'h00
`define WSCP_REG_STATUS 6'h01
`define WSCP_REG_STAGE0 6'h02
`define WSCP_REG_STAGE1 6'h03
`define WSCP_REG_STAGE2 6'h04
`define WSCP_REG_COMMIT 6'h05
`define WSCP_REG_SSR_HI 3'h1

// ****************************************
// Register fields
// ****************************************
`define WSCP_CFG_TABLE_SIZE_FIELD 1:0
`define WSCP_CFG_HIT_LATENCY_FIELD 4:2
`define WSCP_CFG_LAST_SRAM_DRIVER_FLAG 5
`define WSCP_CFG_LAST_FLAG_DRIVER_FLAG 6
`define WSCP_CFG_DEVID 10:8
`define WSCP_CFG_RESET 32'h0000_0064
`define WSCP_STS_BUSY 0
`define WSCP_STS_FULL 1
`define WSCP_STS_REFUSED 2
`define WSCP_STS_FLUSH 0
`define WSCP_CMT_OP 1:0
`define WSCP_CMT_IDX 15:8
`define WSCP_CMT_DATA 2'h0
`define WSCP_CMT_MASK 2'h1
`define WSCP_CMT_GMR 2'h2
`define WSCP_CMT_LEARN 2'h3
`define WSCP_SSR_HIT 31

`endif

// [core/wscp_cmp_mem.v]
`timescale 1ns/1ps

// ****************************************
// Comparand pair storage
// ****************************************
module wscp_cmp_mem #(
    parameter W = 136,
    parameter AW = 4
) (
    input wire clk_sys,
    input wire rst_b,
    input wire wrEn,
    input wire [AW-1:0] wrAddr,
    input wire [W-1:0] wrData,
    input wire rdEn,
    input wire [AW-1:0] rdAddr,
    output reg [W-1:0] rdData_reg
);

reg [W-1:0] mem [0:(1<<AW)-1];

always @(posedge clk_sys) begin
    if (wrEn) begin
        mem[wrAddr] <= wrData;
    end
end

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        rdData_reg <= {W{1'b0}};
    end else if (rdEn) begin
        rdData_reg <= mem[rdAddr];
    end
end

endmodule

// [core/wscp_delay_line.v]
`timescale 1ns/1ps

// ****************************************
// Shift line with selectable tap
// ****************************************
module wscp_delay_line #(
    parameter W = 3,
    parameter DEPTH = 7,
    parameter TAP_W = 3
) (
    input wire clk_sys,
    input wire rst_b,
    input wire [W-1:0] dataIn,
    input wire [TAP_W-1:0] tap,
    output wire [W-1:0] dataOut
);

reg [W-1:0] shift_reg [0:DEPTH-1];
integer k;

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        for (k = 0; k < DEPTH; k = k + 1) begin
            shift_reg[k] <= {W{1'b0}};
        end
    end else begin
        shift_reg[0] <= dataIn;
        for (k = 1; k < DEPTH; k = k + 1) begin
            shift_reg[k] <= shift_reg[k-1];
        end
    end
end

// Tap zero passes the input straight through, bypassing the shift register
assign dataOut = (tap == {TAP_W{1'b0}}) ? dataIn : shift_reg[tap - 1'b1];

endmodule

// [core/wscp_search_core.v]
`timescale 1ns/1ps
`include "wscp_defs.vh"

module wscp_search_core #(
    parameter LOC_AW = 4,
    parameter DEVID_W = 3,
    parameter HIT_LATENCY_FIELD_MAX = 7
) (
    input wire clk_sys,
    input wire rst_b,
    input wire commandValid,
    input wire [8:0] commandBits,
    input wire [`WSCP_KEY_W-1:0] commandData,
    input wire [6:0] localHitIn,
    output wire [1:0] localHitOut,
    input wire upstreamFull,
    output wire downstreamFull,
    output reg [21:0] sramAddrOut_reg,
    output reg sramCe_b_reg,
    output reg sramAle_b_reg,
    output reg sramWe_b_reg,
    output reg sramOe_reg,
    output wire searchValidFlag,
    output wire searchHitFlag,
    output wire searchFlagOe,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest
);

localparam KW = `WSCP_KEY_W;
localparam ENTRIES = 1 << (LOC_AW - 1);
localparam EAW = LOC_AW - 1;
localparam PW = LOC_AW + 8;
localparam P_V = PW - 1;
localparam P_H = PW - 2;
localparam PAD = 19 - DEVID_W - LOC_AW;
localparam S_IDLE = 1'b0;
localparam S_WRITE = 1'b1;

// ****************************************
// Helper functions
// ****************************************
function [EAW-1:0] lowestSet;
    input [ENTRIES-1:0] vec;
    integer i;
    begin
        lowestSet = {EAW{1'b0}};
        for (i = ENTRIES - 1; i >= 0; i = i - 1) begin
            if (vec[i]) begin
                lowestSet = i[EAW-1:0];
            end
        end
    end
endfunction

function [21:0] resultAddr;
    input [PW-1:0] p;
    input [DEVID_W-1:0] dev;
    begin
        resultAddr = {p[PW-3:PW-5], {PAD{1'b0}}, dev, p[LOC_AW-1:0]};
    end
endfunction

// ****************************************
// Configuration and table storage
// ****************************************
reg [31:0] cfg_reg;
reg [KW-1:0] stage_reg;
reg [KW-1:0] tdata [0:2*ENTRIES-1];
reg [KW-1:0] tmask [0:2*ENTRIES-1];
reg [KW-1:0] global_mask_reg [0:15];
reg [ENTRIES-1:0] entValid_reg;
reg [21:0] ssrAddr_reg [0:7];
reg [7:0] ssrHit_reg;
reg learnState_reg;
reg [EAW-1:0] learnSlot_reg;
reg learnRefused_reg;
reg rdDone_reg;
reg [31:0] rdMux;

wire [1:0] table_size_field = cfg_reg[`WSCP_CFG_TABLE_SIZE_FIELD];
wire [2:0] hit_latency_field = cfg_reg[`WSCP_CFG_HIT_LATENCY_FIELD];
wire lastSram = cfg_reg[`WSCP_CFG_LAST_SRAM_DRIVER_FLAG];
wire lastFlag = cfg_reg[`WSCP_CFG_LAST_FLAG_DRIVER_FLAG];
wire [DEVID_W-1:0] devId = cfg_reg[`WSCP_CFG_DEVID];
wire learnBusy = (learnState_reg == S_WRITE);
wire tableFull = &entValid_reg;
wire [EAW-1:0] freeSlot = lowestSet(~entValid_reg);

// ****************************************
// Register bus decode
// ****************************************
wire isCommit = (avs_address == `WSCP_REG_COMMIT);
wire wrCommit = avs_write && isCommit && !learnBusy;
wire [1:0] cmtOp = avs_writedata[`WSCP_CMT_OP];
wire [7:0] cmtIdx = avs_writedata[`WSCP_CMT_IDX];
wire learnReq = wrCommit && (cmtOp == `WSCP_CMT_LEARN);
wire learnOk = learnReq && upstreamFull && !tableFull;
wire wrFlush = avs_write && (avs_address == `WSCP_REG_STATUS) && avs_writedata[`WSCP_STS_FLUSH];
wire [2*KW-1:0] cmpRd;

assign avs_waitrequest = (avs_read && !rdDone_reg) || (avs_write && isCommit && learnBusy);
assign downstreamFull = upstreamFull && tableFull;

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        cfg_reg <= `WSCP_CFG_RESET;
        stage_reg <= {KW{1'b0}};
    end else if (avs_write) begin
        case (avs_address)
            `WSCP_REG_CONFIG: cfg_reg <= avs_writedata;
            `WSCP_REG_STAGE0: stage_reg[31:0] <= avs_writedata;
            `WSCP_REG_STAGE1: stage_reg[63:32] <= avs_writedata;
            `WSCP_REG_STAGE2: stage_reg[KW-1:64] <= avs_writedata[KW-65:0];
            default: stage_reg <= stage_reg;
        endcase
    end
end

always @* begin
    rdMux = 32'h0000_0000;
    if (avs_address[5:3] == `WSCP_REG_SSR_HI) begin
        rdMux[21:0] = ssrAddr_reg[avs_address[2:0]];
        rdMux[`WSCP_SSR_HIT] = ssrHit_reg[avs_address[2:0]];
    end else begin
        case (avs_address)
            `WSCP_REG_CONFIG: rdMux = cfg_reg;
            `WSCP_REG_STATUS: begin
                rdMux[`WSCP_STS_BUSY] = learnBusy;
                rdMux[`WSCP_STS_FULL] = tableFull;
                rdMux[`WSCP_STS_REFUSED] = learnRefused_reg;
            end
            `WSCP_REG_STAGE0: rdMux = stage_reg[31:0];
            `WSCP_REG_STAGE1: rdMux = stage_reg[63:32];
            `WSCP_REG_STAGE2: rdMux[KW-65:0] = stage_reg[KW-1:64];
            default: rdMux = 32'h0000_0000;
        endcase
    end
end

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        rdDone_reg <= 1'b0;
        avs_readdata <= 32'h0000_0000;
    end else begin
        rdDone_reg <= avs_read && !rdDone_reg;
        if (avs_read && !rdDone_reg) begin
            avs_readdata <= rdMux;
        end
    end
end

// ****************************************
// Learn from a stored comparand pair
// ****************************************
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        learnState_reg <= S_IDLE;
        learnSlot_reg <= {EAW{1'b0}};
        learnRefused_reg <= 1'b0;
    end else begin
        case (learnState_reg)
            S_IDLE: begin
                if (learnOk) begin
                    learnState_reg <= S_WRITE;
                    learnSlot_reg <= freeSlot;
                    learnRefused_reg <= 1'b0;
                end else if (learnReq) begin
                    learnRefused_reg <= 1'b1;
                end
            end
            S_WRITE: learnState_reg <= S_IDLE;
            default: learnState_reg <= S_IDLE;
        endcase
    end
end

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        entValid_reg <= {ENTRIES{1'b0}};
    end else begin
        if (wrFlush) begin
            entValid_reg <= {ENTRIES{1'b0}};
        end
        // A learn landing with a flush keeps its entry
        if (learnBusy) begin
            entValid_reg[learnSlot_reg] <= 1'b1;
        end else if (wrCommit && cmtOp == `WSCP_CMT_DATA && !cmtIdx[0]) begin
            entValid_reg[cmtIdx[LOC_AW-1:1]] <= 1'b1;
        end
    end
end

always @(posedge clk_sys) begin
    if (wrCommit && cmtOp == `WSCP_CMT_DATA) begin
        tdata[cmtIdx[LOC_AW-1:0]] <= stage_reg;
    end
    if (wrCommit && cmtOp == `WSCP_CMT_MASK) begin
        tmask[cmtIdx[LOC_AW-1:0]] <= stage_reg;
    end
    if (wrCommit && cmtOp == `WSCP_CMT_GMR) begin
        global_mask_reg[cmtIdx[3:0]] <= stage_reg;
    end
    if (learnBusy) begin
        tdata[{learnSlot_reg, 1'b0}] <= cmpRd[2*KW-1:KW];
        tdata[{learnSlot_reg, 1'b1}] <= cmpRd[KW-1:0];
        tmask[{learnSlot_reg, 1'b0}] <= {KW{1'b0}};
        tmask[{learnSlot_reg, 1'b1}] <= {KW{1'b0}};
    end
end

// ****************************************
// Two-cycle command capture
// ****************************************
reg phaseB_reg;
reg [KW-1:0] keyA_reg;
reg [2:0] gmrIdx_reg;
reg [2:0] hiBits_reg;

wire opSearch = commandValid && (commandBits[`WSCP_CMD_OP] == `WSCP_OP_SEARCH);
wire isA = !phaseB_reg && opSearch && !commandBits[`WSCP_CMD_ZERO];
wire isB = phaseB_reg && opSearch;

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        phaseB_reg <= 1'b0;
        keyA_reg <= {KW{1'b0}};
        gmrIdx_reg <= 3'h0;
        hiBits_reg <= 3'h0;
    end else begin
        phaseB_reg <= isA;
        if (isA) begin
            keyA_reg <= commandData;
            gmrIdx_reg <= commandBits[`WSCP_CMD_GMR];
            hiBits_reg <= commandBits[`WSCP_CMD_HI];
        end
    end
end

wscp_cmp_mem #(
    .W(2*KW),
    .AW(4)
) uCmpMem (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrEn(isB),
    .wrAddr(commandBits[`WSCP_CMD_CMP]),
    .wrData({keyA_reg, commandData}),
    .rdEn(learnOk),
    .rdAddr(cmtIdx[3:0]),
    .rdData_reg(cmpRd)
);

// ****************************************
// Parallel compare
// ****************************************
wire [KW-1:0] gmrEven = global_mask_reg[{gmrIdx_reg, 1'b0}];
wire [KW-1:0] gmrOdd = global_mask_reg[{gmrIdx_reg, 1'b1}];
wire [KW-1:0] keyEven = keyA_reg & gmrEven;
wire [KW-1:0] keyOdd = commandData & gmrOdd;
wire [ENTRIES-1:0] matchVec;

genvar g;
generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : gCmp
        wire [KW-1:0] missE = (keyEven ^ (tdata[2*g] & gmrEven)) & ~tmask[2*g];
        wire [KW-1:0] missO = (keyOdd ^ (tdata[2*g+1] & gmrOdd)) & ~tmask[2*g+1];
        assign matchVec[g] = entValid_reg[g] && !(|missE) && !(|missO);
    end
endgenerate

wire hitAny = |matchVec;
wire [LOC_AW-1:0] hitLoc = hitAny ? {lowestSet(matchVec), 1'b0} : {LOC_AW{1'b0}};
wire [PW-1:0] newStage = {isB, isB && hitAny, hiBits_reg, commandBits[`WSCP_CMD_SSR], hitLoc};

// ****************************************
// Result pipeline and status registers
// ****************************************
reg [PW-1:0] pipe_reg [1:5];
reg arbWin_reg;
reg arbUp_reg;
integer s;

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        for (s = 1; s <= 5; s = s + 1) begin
            pipe_reg[s] <= {PW{1'b0}};
        end
    end else begin
        pipe_reg[1] <= newStage;
        for (s = 2; s <= 5; s = s + 1) begin
            pipe_reg[s] <= pipe_reg[s-1];
        end
    end
end

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        for (s = 0; s < 8; s = s + 1) begin
            ssrAddr_reg[s] <= 22'h00_0000;
        end
        ssrHit_reg <= 8'h00;
    end else if (pipe_reg[3][P_V]) begin
        ssrAddr_reg[pipe_reg[3][PW-6:PW-8]] <= resultAddr(pipe_reg[3], devId);
        ssrHit_reg[pipe_reg[3][PW-6:PW-8]] <= pipe_reg[3][P_H];
    end
end

// ****************************************
// Block arbitration and output drive
// ****************************************
wire [PW-1:0] p4 = pipe_reg[4];
wire arbUp = |localHitIn;
wire arbWin = p4[P_H] && !arbUp;

assign localHitOut = {2{(table_size_field != `WSCP_TABLE_SIZE_FIELD_ONE) && p4[P_V] && p4[P_H]}};

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        arbWin_reg <= 1'b0;
        arbUp_reg <= 1'b0;
    end else begin
        arbWin_reg <= arbWin;
        arbUp_reg <= arbUp;
    end
end

reg [PW-1:0] sel;
reg selWin;
reg selUp;

always @* begin
    case (table_size_field)
        `WSCP_TABLE_SIZE_FIELD_ONE: begin
            sel = pipe_reg[`WSCP_LAT_ONE-1];
            selWin = pipe_reg[`WSCP_LAT_ONE-1][P_H];
            selUp = 1'b0;
        end
        `WSCP_TABLE_SIZE_FIELD_EIGHT: begin
            sel = pipe_reg[`WSCP_LAT_EIGHT-1];
            selWin = arbWin;
            selUp = arbUp;
        end
        default: begin
            sel = pipe_reg[`WSCP_LAT_FULL-1];
            selWin = arbWin_reg;
            selUp = arbUp_reg;
        end
    endcase
end

wire globalMiss = !selUp && !sel[P_H];
wire drvSram = sel[P_V] && (selWin || (globalMiss && lastSram));
wire drvFlag = sel[P_V] && (selWin || (globalMiss && lastFlag));

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        sramAddrOut_reg <= 22'h00_0000;
        sramCe_b_reg <= 1'b1;
        sramAle_b_reg <= 1'b1;
        sramWe_b_reg <= 1'b1;
        sramOe_reg <= 1'b0;
    end else begin
        sramAddrOut_reg <= drvSram ? resultAddr(sel, devId) : 22'h00_0000;
        sramCe_b_reg <= !drvSram;
        sramAle_b_reg <= !drvSram;
        sramWe_b_reg <= 1'b1;
        sramOe_reg <= drvSram;
    end
end

reg [2:0] flagStage_reg;

always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        flagStage_reg <= 3'h0;
    end else begin
        flagStage_reg <= {drvFlag, drvFlag, drvFlag && selWin};
    end
end

wscp_delay_line #(
    .W(3),
    .DEPTH(HIT_LATENCY_FIELD_MAX),
    .TAP_W(3)
) uFlagDelay (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .dataIn(flagStage_reg),
    .tap(hit_latency_field),
    .dataOut({searchFlagOe, searchValidFlag, searchHitFlag})
);

endmodule

// [sim/wscp_sva.sv]
`timescale 1ns/1ps
// ****
// Search pipeline checker
// ****
module wscp_sva (
    input wire clk_sys,
    input wire rst_b,
    input wire commandValid,
    input wire [8:0] commandBits,
    input wire [6:0] localHitIn,
    input wire [21:0] sramAddrOut_reg,
    input wire sramCe_b_reg,
    input wire sramAle_b_reg,
    input wire sramWe_b_reg,
    input wire sramOe_reg,
    input wire searchValidFlag,
    input wire searchHitFlag,
    input wire searchFlagOe,
    input wire [5:0] avs_address,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire avs_waitrequest
);
    reg [6:0] cfg_reg;
    reg phaseB_reg;
    reg [7:0] oeHist_reg;
    reg [4:0] cfgAge_reg;
    wire opA = commandValid && commandBits[1:0] == 2'h2;
    wire takeA = opA && !commandBits[2] && !phaseB_reg;
    wire [2:0] hitDly = cfg_reg[4:2];
    wire oeDly = (hitDly == 3'h0) ? sramOe_reg : oeHist_reg[hitDly - 3'h1];
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg <= 7'h64;
            phaseB_reg <= 1'b0;
            oeHist_reg <= 8'h00;
            cfgAge_reg <= 5'h00;
        end else begin
            phaseB_reg <= takeA;
            oeHist_reg <= {oeHist_reg[6:0], sramOe_reg};
            if (avs_write && !avs_waitrequest && avs_address == 6'h00) begin
                cfg_reg <= avs_writedata[6:0];
                cfgAge_reg <= 5'h00;
            end else if (cfgAge_reg != 5'h1f) begin
                cfgAge_reg <= cfgAge_reg + 5'h01;
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    AST_LAT_ONE: assert property (takeA && cfg_reg[1:0] == 2'h0 && cfg_reg[5] ##1 opA |-> ##4 sramOe_reg)
        else $error("result late for single device");
    AST_LAT_EIGHT: assert property (takeA && cfg_reg[1:0] == 2'h1 && cfg_reg[5] ##1 opA ##4 localHitIn == 7'h00
        |-> ##1 sramOe_reg)
        else $error("result late for block");
    AST_EVEN: assert property (sramOe_reg |-> !sramAddrOut_reg[0])
        else $error("odd result address");
    AST_TOP_BITS: assert property (takeA && cfg_reg[1:0] == 2'h0 && cfg_reg[5] ##1 opA ##4 1'b1
        |-> sramAddrOut_reg[21:19] == $past(commandBits[8:6], 5))
        else $error("address top bits wrong");
    AST_STROBES: assert property (sramOe_reg |-> !sramCe_b_reg && !sramAle_b_reg && sramWe_b_reg)
        else $error("strobes wrong in result cycle");
    AST_RATE: assert property (sramOe_reg |=> !sramOe_reg)
        else $error("result stood two cycles");
    AST_FLAG_SHIFT: assert property (cfgAge_reg == 5'h1f && cfg_reg[1:0] == 2'h0 && cfg_reg[6:5] == 2'h3
        |-> searchValidFlag == oeDly)
        else $error("flag shift wrong");
    AST_HIT_VALID: assert property (searchHitFlag |-> searchValidFlag && searchFlagOe)
        else $error("hit without valid");
    AST_UPSTREAM_WINS: assert property (sramOe_reg && cfg_reg[1:0] == 2'h1 |-> $past(localHitIn) == 7'h00)
        else $error("drove after upstream hit");
    cover property (searchHitFlag);
    cover property (sramOe_reg && cfg_reg[1:0] == 2'h1);
    cover property (takeA ##1 !opA);
endmodule

// [sim/wscp_host_model.sv]
`timescale 1ns/1ps
// ****
// Host command driver
// ****
module wscp_host_model (
    input wire clk_sys,
    output reg commandValid,
    output reg [8:0] commandBits,
    output reg [67:0] commandData
);
    initial begin
        commandValid = 1'b0;
        commandBits = 9'h000;
        commandData = 68'h0;
    end
    task search(input [2:0] g, input [2:0] hi, input [3:0] cmp, input [2:0] st, input [67:0] a,
        input [67:0] b, input bad);
        begin
            @(posedge clk_sys);
            commandValid <= 1'b1;
            commandBits <= {hi, g, 1'b0, 2'h2};
            commandData <= a;
            @(posedge clk_sys);
            commandValid <= !bad;
            commandBits <= {st, cmp, 2'h2};
            commandData <= b;
        end
    endtask
    // Released bus shows inverted data, never the stale word
    task idle;
        begin
            @(posedge clk_sys);
            commandValid <= 1'b0;
            commandBits <= ~commandBits;
            commandData <= ~commandData;
        end
    endtask
endmodule

// [sim/test_wide_search_command_pipeline.sv]
`timescale 1ns/1ps
// ****
// Wide search bench
// ****
module test_wide_search_command_pipeline;
    reg clk_sys, rst_b, upstreamFull, avs_read, avs_write;
    reg [6:0] localHitIn;
    reg [5:0] avs_address;
    reg [31:0] avs_writedata, rd;
    wire commandValid, downstreamFull, sramCe_b_reg, sramAle_b_reg, sramWe_b_reg, sramOe_reg;
    wire searchValidFlag, searchHitFlag, searchFlagOe, avs_waitrequest;
    wire [8:0] commandBits;
    wire [67:0] commandData;
    wire [1:0] localHitOut;
    wire [21:0] sramAddrOut_reg;
    wire [31:0] avs_readdata;
    integer failures, n_checks, cycles, seedDummy, i, w, s;
    reg [67:0] tabData[0:15];
    reg [67:0] tabMask[0:15];
    reg [67:0] gm[0:15];
    reg [67:0] kA, kB;
    reg [7:0] valid;
    reg [2:0] p, lastStat;
    reg [4:0] lastLoc;
    reg [21:0] lastAddr;
    reg [21:0] addrQ[$];
    reg hitQ[$];
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    wscp_search_core i_dut (.clk_sys, .rst_b, .commandValid, .commandBits, .commandData, .localHitIn,
        .localHitOut, .upstreamFull, .downstreamFull, .sramAddrOut_reg, .sramCe_b_reg, .sramAle_b_reg,
        .sramWe_b_reg, .sramOe_reg, .searchValidFlag, .searchHitFlag, .searchFlagOe, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
    wscp_host_model i_host (.clk_sys, .commandValid, .commandBits, .commandData);
    task check(input string name, input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("CHECK FAILED %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d failures %0d", n_checks, failures);
            if (failures == 0 && n_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task bus(input wr, input [5:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= wr;
            avs_read <= !wr;
            do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask
    task put68(input [1:0] op, input [7:0] idx, input [67:0] v);
        begin
            bus(1'b1, 6'h02, v[31:0]);
            bus(1'b1, 6'h03, v[63:32]);
            bus(1'b1, 6'h04, {28'h000_0000, v[67:64]});
            bus(1'b1, 6'h05, {16'h0000, idx, 6'h00, op});
        end
    endtask
    function [67:0] rnd68(input integer unused);
        reg [95:0] r;
        begin
            r = {$urandom, $urandom, $urandom};
            rnd68 = r[67:0];
        end
    endfunction
    // Lowest matching wide entry, 5'h10 on a miss
    function [4:0] lookup(input [2:0] g, input [67:0] a, input [67:0] b);
        integer j;
        begin
            lookup = 5'h10;
            for (j = 14; j >= 0; j = j - 2)
                if (valid[j / 2] && ((a ^ tabData[j]) & gm[2 * g] & ~tabMask[j]) == 68'h0
                    && ((b ^ tabData[j + 1]) & gm[2 * g + 1] & ~tabMask[j + 1]) == 68'h0)
                    lookup = j[4:0];
        end
    endfunction
    task srch(input [2:0] g, input [3:0] cmp, input bad, input drive);
        reg [2:0] hi;
        begin
            hi = 3'($urandom);
            lastStat = 3'($urandom);
            lastLoc = lookup(g, kA, kB);
            lastAddr = {hi, 12'h000, 3'h5, lastLoc[4] ? 4'h0 : lastLoc[3:0]};
            i_host.search(g, hi, cmp, lastStat, kA, kB, bad);
            if (!bad && drive) begin
                addrQ.push_back(lastAddr);
                hitQ.push_back(!lastLoc[4]);
            end
        end
    endtask
    task drain;
        begin
            i_host.idle;
            repeat (20) @(posedge clk_sys);
            check("pending results", addrQ.size() + hitQ.size(), 0);
        end
    endtask
    always @(negedge clk_sys) begin
        if (sramOe_reg === 1'b1)
            check("sram address", sramAddrOut_reg, addrQ.size() ? addrQ.pop_front() : 22'h3f_ffff);
        if (searchValidFlag === 1'b1)
            check("hit flag", {1'b0, searchHitFlag}, hitQ.size() ? {1'b0, hitQ.pop_front()} : 2'h2);
        cycles = cycles + 1;
        if (cycles > 20000) begin
            failures = failures + 1;
            report_and_stop;
        end
    end
    initial begin
        rst_b = 1'b0;
        localHitIn = 7'h00;
        upstreamFull = 1'b1;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        failures = 0;
        n_checks = 0;
        cycles = 0;
        valid = 8'h00;
        seedDummy = $urandom(32);
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        bus(1'b0, 6'h00, 0);
        check("config reset", rd, 32'h0000_0064);
        bus(1'b0, 6'h3f, 0);
        check("unmapped read", rd, 32'h0000_0000);
        for (i = 0; i < 16; i = i + 1) begin
            gm[i] = (i == 2) ? {{60{1'b1}}, 8'h00} : {68{1'b1}};
            tabMask[i] = (i == 12) ? {68{1'b1}} : 68'h0;
            tabData[i] = (i == 10 || i == 11) ? tabData[i - 4] : rnd68(0);
            put68(2'h2, i[7:0], gm[i]);
            put68(2'h1, i[7:0], tabMask[i]);
            put68(2'h0, i[7:0], tabData[i]);
        end
        valid = 8'hff;
        check("downstream full", downstreamFull, 1);
        for (i = 0; i < 16; i = i + 1) begin
            bus(1'b1, 6'h00, 32'h0000_0560 | ((i % 8) << 2) | (i / 8));
            for (w = 0; w < 3; w = w + 1) begin
                p = 3'($urandom);
                s = $urandom % 9;
                kA = (s == 8) ? rnd68(0) : tabData[2 * s];
                kB = (s == 8) ? rnd68(0) : tabData[2 * s + 1];
                if (p == 3'h1 && $urandom % 2)
                    kA[0] = ~kA[0];
                else if (p == 3'h1)
                    kB[0] = ~kB[0];
                srch(p, 4'($urandom), 1'b0, 1'b1);
            end
            drain;
            bus(1'b0, 6'h08 + {3'h0, lastStat}, 0);
            check("status hit", rd[31], !lastLoc[4]);
            check("status address", rd[21:0], lastAddr);
        end
        bus(1'b1, 6'h00, 32'h0000_0505);
        localHitIn <= 7'h04;
        kA = tabData[4];
        kB = tabData[5];
        srch(3'h0, 4'h0, 1'b0, 1'b0);
        i_host.idle;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check("local hit out", localHitOut, 2'h3);
        repeat (10) @(posedge clk_sys);
        localHitIn <= 7'h00;
        bus(1'b1, 6'h00, 32'h0000_0564);
        kA = rnd68(0);
        kB = rnd68(0);
        srch(3'h0, 4'h9, 1'b0, 1'b1);
        i_host.idle;
        srch(3'h0, 4'h3, 1'b1, 1'b1);
        drain;
        bus(1'b0, 6'h01, 0);
        check("status full", rd[2:0], 3'h2);
        bus(1'b1, 6'h05, 32'h0000_0903);
        bus(1'b0, 6'h01, 0);
        check("refused when full", rd[2:0], 3'h6);
        bus(1'b1, 6'h01, 32'h0000_0001);
        valid = 8'h00;
        upstreamFull <= 1'b0;
        bus(1'b1, 6'h05, 32'h0000_0903);
        bus(1'b0, 6'h01, 0);
        check("refused upstream", rd[2:0], 3'h4);
        check("downstream clear", downstreamFull, 0);
        upstreamFull <= 1'b1;
        bus(1'b1, 6'h05, 32'h0000_0903);
        bus(1'b0, 6'h01, 0);
        check("learn accepted", rd[2:0], 3'h0);
        valid = 8'h01;
        tabData[0] = kA;
        tabData[1] = kB;
        tabMask[0] = 68'h0;
        tabMask[1] = 68'h0;
        srch(3'h0, 4'h0, 1'b0, 1'b1);
        drain;
        bus(1'b0, 6'h08 + {3'h0, lastStat}, 0);
        check("learned hit", {rd[31], rd[21:0]}, {1'b1, lastAddr[21:4], 4'h0});
        report_and_stop;
    end
endmodule
bind wscp_search_core wscp_sva i_sva (.clk_sys, .rst_b, .commandValid, .commandBits, .localHitIn,
    .sramAddrOut_reg, .sramCe_b_reg, .sramAle_b_reg, .sramWe_b_reg, .sramOe_reg, .searchValidFlag,
    .searchHitFlag, .searchFlagOe, .avs_address, .avs_write, .avs_writedata, .avs_waitrequest);
